// file: inc/ecc_fix_pkg.sv
// Shared types and constants for the correctable error handler.
// Assumes 32-bit memory words protected by a 7-bit SEC-DED code.
package ecc_fix_pkg;
	localparam int DATA_W = 32;
	localparam int CHK_W = 7;
	localparam int ADDR_W = 16;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

	// Access source and kind
	typedef enum logic [1:0] {
		SRC_CORE_LOAD = 2'b00,
		SRC_CORE_STORE = 2'b01,
		SRC_DMA_READ = 2'b10,
		SRC_DMA_WRITE = 2'b11
	} access_e;

	// One memory read result offered for checking
	typedef struct packed {
		logic valid;
		access_e kind;
		logic speculative;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [CHK_W-1:0] chk;
	} mem_rd_s;

	// One memory write request
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [CHK_W-1:0] chk;
	} mem_wr_s;

	// Check bits for a data word, Hamming positions 1..38 plus overall parity
	function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
		logic [CHK_W-1:0] c;
		logic [5:0] pos;
		int j;
		c = '0;
		j = 0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				pos = 6'(p);
				for (int b = 0; b < 6; b++) begin
					if (pos[b]) begin
						c[b] = c[b] ^ d[j];
					end
				end
				j++;
			end
		end
		c[6] = ^{d, c[5:0]};
		return c;
	endfunction : ecc_gen
endpackage : ecc_fix_pkg

// file: design/ecc_fix.sv
// Correctable ECC handler for local data and instruction memories.
// Assumes memory read results arrive one cycle after the read, from the same clock.
// What this block does
// - Load error: correct in line, write back
// - Count data memory correctable errors in core
// - Data count at threshold raises local interrupt
// - Core accesses count or repair only when non-speculative
// - Store error: correct in line, write back
// - DMA instruction memory errors get own counter
// - Instruction count at threshold raises interrupt
// - DMA instruction read: correct, return, write back
// - DMA data read: correct, count, write back
// - Counters hold counts only, no addresses
// - DMA write stores whole word, fresh checks
// - No ECC check on DMA writes
`timescale 1ns/1ps
module ecc_fix (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Thresholds
	input wire logic [ecc_fix_pkg::CNT_W-1:0] data_thresh,
	input wire logic [ecc_fix_pkg::CNT_W-1:0] inst_thresh,
	// Read results from the memories
	input wire ecc_fix_pkg::mem_rd_s data_rd,
	input wire ecc_fix_pkg::mem_rd_s inst_rd,
	// DMA write requests
	input wire logic dma_wr_data_sel,
	input wire logic dma_wr_valid,
	input wire logic [ecc_fix_pkg::ADDR_W-1:0] dma_wr_addr,
	input wire logic [ecc_fix_pkg::DATA_W-1:0] dma_wr_data,
	// Corrected read data
	output logic data_out_valid,
	output logic [ecc_fix_pkg::DATA_W-1:0] data_out,
	output logic data_out_uncorr,
	output logic inst_out_valid,
	output logic [ecc_fix_pkg::DATA_W-1:0] inst_out,
	output logic inst_out_uncorr,
	// Writes to the memories
	output ecc_fix_pkg::mem_wr_s data_wr,
	output ecc_fix_pkg::mem_wr_s inst_wr,
	// Counts and interrupts
	output logic [ecc_fix_pkg::CNT_W-1:0] data_err_count,
	output logic [ecc_fix_pkg::CNT_W-1:0] inst_err_count,
	output logic data_corr_irq,
	output logic inst_corr_irq
);
	import ecc_fix_pkg::*;

	// Decode results
	typedef struct packed {
		logic single;
		logic double;
		logic [DATA_W-1:0] fixed;
	} dec_s;

	function automatic dec_s ecc_dec(input logic [DATA_W-1:0] d, input logic [CHK_W-1:0] c);
		dec_s r;
		logic [CHK_W-1:0] g;
		logic [5:0] syn;
		logic par;
		logic [5:0] pos;
		int j;
		g = ecc_gen(d);
		syn = g[5:0] ^ c[5:0];
		par = ^{d, c};
		r.fixed = d;
		// A syndrome past the last code position means three or more flips
		r.single = par && syn <= 6'h26;
		r.double = ((syn != 6'h00) && !par) || (par && syn > 6'h26);
		j = 0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				pos = 6'(p);
				if (par && syn == pos) begin
					r.fixed[j] = ~d[j];
				end
				j++;
			end
		end
		return r;
	endfunction : ecc_dec

	dec_s data_dec;
	dec_s inst_dec;
	logic data_fix_ok;
	logic inst_fix_ok;
	logic data_bit_err;
	logic inst_bit_err;

	logic data_out_valid_q, data_out_valid_d;
	logic [DATA_W-1:0] data_out_q, data_out_d;
	logic data_out_uncorr_q, data_out_uncorr_d;
	logic inst_out_valid_q, inst_out_valid_d;
	logic [DATA_W-1:0] inst_out_q, inst_out_d;
	logic inst_out_uncorr_q, inst_out_uncorr_d;
	mem_wr_s data_wr_q, data_wr_d;
	mem_wr_s inst_wr_q, inst_wr_d;
	logic [CNT_W-1:0] data_cnt_q, data_cnt_d;
	logic [CNT_W-1:0] inst_cnt_q, inst_cnt_d;
	logic data_irq_q, data_irq_d;
	logic inst_irq_q, inst_irq_d;

	always_comb begin
		// Data memory: reads only, core reads only when non-speculative
		data_dec = ecc_dec(data_rd.data, data_rd.chk);
		data_bit_err = data_rd.valid && data_rd.kind != SRC_DMA_WRITE && data_dec.single;
		data_fix_ok = data_bit_err && (data_rd.kind == SRC_DMA_READ || !data_rd.speculative);
	end

	always_comb begin
		// Instruction memory: only DMA reads are checked here
		inst_dec = ecc_dec(inst_rd.data, inst_rd.chk);
		inst_bit_err = inst_rd.valid && inst_rd.kind == SRC_DMA_READ && inst_dec.single;
		inst_fix_ok = inst_bit_err;
	end

	always_comb begin
		// Data memory return; a DMA write kind is never checked or reported
		data_out_valid_d = data_rd.valid && data_rd.kind != SRC_DMA_WRITE;
		data_out_d = data_dec.fixed;
		data_out_uncorr_d = data_out_valid_d && data_dec.double;
	end

	// Registered data memory return
	always_ff @(posedge clk) begin
		if (srst) begin
			data_out_valid_q <= 1'b0;
			data_out_q <= '0;
			data_out_uncorr_q <= 1'b0;
		end else begin
			data_out_valid_q <= data_out_valid_d;
			data_out_q <= data_out_d;
			data_out_uncorr_q <= data_out_uncorr_d;
		end
	end

	always_comb begin
		// Instruction memory return, DMA reads only
		inst_out_valid_d = inst_rd.valid && inst_rd.kind == SRC_DMA_READ;
		inst_out_d = inst_dec.fixed;
		inst_out_uncorr_d = inst_out_valid_d && inst_dec.double;
	end

	// Registered instruction memory return
	always_ff @(posedge clk) begin
		if (srst) begin
			inst_out_valid_q <= 1'b0;
			inst_out_q <= '0;
			inst_out_uncorr_q <= 1'b0;
		end else begin
			inst_out_valid_q <= inst_out_valid_d;
			inst_out_q <= inst_out_d;
			inst_out_uncorr_q <= inst_out_uncorr_d;
		end
	end

	always_comb begin
		// Data memory write; a DMA write in the same cycle wins
		// A dropped write-back leaves the error for the next read to find
		data_wr_d = '0;
		if (dma_wr_valid && dma_wr_data_sel) begin
			data_wr_d.valid = 1'b1;
			data_wr_d.addr = dma_wr_addr;
			data_wr_d.data = dma_wr_data;
			data_wr_d.chk = ecc_gen(dma_wr_data);
		end else if (data_fix_ok) begin
			data_wr_d.valid = 1'b1;
			data_wr_d.addr = data_rd.addr;
			data_wr_d.data = data_dec.fixed;
			data_wr_d.chk = ecc_gen(data_dec.fixed);
		end
	end

	// Registered data memory write
	always_ff @(posedge clk) begin
		if (srst) begin
			data_wr_q <= '0;
		end else begin
			data_wr_q <= data_wr_d;
		end
	end

	always_comb begin
		// Instruction memory write; a DMA write in the same cycle wins
		inst_wr_d = '0;
		if (dma_wr_valid && !dma_wr_data_sel) begin
			inst_wr_d.valid = 1'b1;
			inst_wr_d.addr = dma_wr_addr;
			inst_wr_d.data = dma_wr_data;
			inst_wr_d.chk = ecc_gen(dma_wr_data);
		end else if (inst_fix_ok) begin
			inst_wr_d.valid = 1'b1;
			inst_wr_d.addr = inst_rd.addr;
			inst_wr_d.data = inst_dec.fixed;
			inst_wr_d.chk = ecc_gen(inst_dec.fixed);
		end
	end

	// Registered instruction memory write
	always_ff @(posedge clk) begin
		if (srst) begin
			inst_wr_q <= '0;
		end else begin
			inst_wr_q <= inst_wr_d;
		end
	end

	always_comb begin
		// Data occurrence count, no address kept
		// Holds at the top so a reached threshold is not lost
		data_cnt_d = data_cnt_q;
		if (data_fix_ok && data_cnt_q != CNT_MAX) begin
			data_cnt_d = data_cnt_q + 16'h0001;
		end
	end

	// Registered data count
	always_ff @(posedge clk) begin
		if (srst) begin
			data_cnt_q <= CNT_RESET;
		end else begin
			data_cnt_q <= data_cnt_d;
		end
	end

	always_comb begin
		// Instruction occurrence count, no address kept
		inst_cnt_d = inst_cnt_q;
		if (inst_fix_ok && inst_cnt_q != CNT_MAX) begin
			inst_cnt_d = inst_cnt_q + 16'h0001;
		end
	end

	// Registered instruction count
	always_ff @(posedge clk) begin
		if (srst) begin
			inst_cnt_q <= CNT_RESET;
		end else begin
			inst_cnt_q <= inst_cnt_d;
		end
	end

	always_comb begin
		// Level while the count is at or above a nonzero threshold
		data_irq_d = data_cnt_d >= data_thresh && data_thresh != CNT_RESET;
	end

	// Registered data interrupt
	always_ff @(posedge clk) begin
		if (srst) begin
			data_irq_q <= 1'b0;
		end else begin
			data_irq_q <= data_irq_d;
		end
	end

	always_comb begin
		// Level while the count is at or above a nonzero threshold
		inst_irq_d = inst_cnt_d >= inst_thresh && inst_thresh != CNT_RESET;
	end

	// Registered instruction interrupt
	always_ff @(posedge clk) begin
		if (srst) begin
			inst_irq_q <= 1'b0;
		end else begin
			inst_irq_q <= inst_irq_d;
		end
	end

	assign data_out_valid = data_out_valid_q;
	assign data_out = data_out_q;
	assign data_out_uncorr = data_out_uncorr_q;
	assign inst_out_valid = inst_out_valid_q;
	assign inst_out = inst_out_q;
	assign inst_out_uncorr = inst_out_uncorr_q;
	assign data_wr = data_wr_q;
	assign inst_wr = inst_wr_q;
	assign data_err_count = data_cnt_q;
	assign inst_err_count = inst_cnt_q;
	assign data_corr_irq = data_irq_q;
	assign inst_corr_irq = inst_irq_q;
endmodule : ecc_fix

// file: tb/ecc_fix_properties.sv
// Port assertions for the correctable error handler.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
module ecc_fix_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Inputs
	input wire logic [ecc_fix_pkg::CNT_W-1:0] data_thresh,
	input wire logic [ecc_fix_pkg::CNT_W-1:0] inst_thresh,
	input wire ecc_fix_pkg::mem_rd_s data_rd,
	input wire ecc_fix_pkg::mem_rd_s inst_rd,
	input wire logic dma_wr_data_sel,
	input wire logic dma_wr_valid,
	input wire logic [ecc_fix_pkg::DATA_W-1:0] dma_wr_data,
	// Outputs
	input wire ecc_fix_pkg::mem_wr_s data_wr,
	input wire ecc_fix_pkg::mem_wr_s inst_wr,
	input wire logic [ecc_fix_pkg::CNT_W-1:0] data_err_count,
	input wire logic [ecc_fix_pkg::CNT_W-1:0] inst_err_count,
	input wire logic data_corr_irq,
	input wire logic inst_corr_irq
);
	import ecc_fix_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire d_cor = data_rd.valid && !data_rd.speculative && data_rd.kind != SRC_DMA_WRITE
		&& ^{data_rd.data, data_rd.chk};
	wire i_cor = inst_rd.valid && inst_rd.kind == SRC_DMA_READ && ^{inst_rd.data, inst_rd.chk};
	property p_dcnt;
		d_cor && data_err_count != CNT_MAX |=> data_err_count == $past(data_err_count) + 16'h0001;
	endproperty
	a_dcnt: assert property (p_dcnt) else $error("data count");
	property p_dwb;
		d_cor && !(dma_wr_valid && dma_wr_data_sel) |=> data_wr.valid
			&& data_wr.addr == $past(data_rd.addr);
	endproperty
	a_dwb: assert property (p_dwb) else $error("data write-back");
	property p_spec;
		data_rd.valid && data_rd.speculative && !dma_wr_valid
			&& (data_rd.kind == SRC_CORE_LOAD || data_rd.kind == SRC_CORE_STORE) |=>
			$stable(data_err_count) && !data_wr.valid;
	endproperty
	a_spec: assert property (p_spec) else $error("speculative action");
	property p_icnt;
		i_cor && inst_err_count != CNT_MAX |=> inst_err_count == $past(inst_err_count) + 16'h0001;
	endproperty
	a_icnt: assert property (p_icnt) else $error("inst count");
	property p_iwb;
		i_cor && !(dma_wr_valid && !dma_wr_data_sel) |=> inst_wr.valid
			&& inst_wr.addr == $past(inst_rd.addr);
	endproperty
	a_iwb: assert property (p_iwb) else $error("inst write-back");
	property p_dma;
		dma_wr_valid && dma_wr_data_sel |=> data_wr.valid && data_wr.data == $past(dma_wr_data);
	endproperty
	a_dma: assert property (p_dma) else $error("dma write");
	property p_chk;
		data_wr.valid |-> !(^{data_wr.data, data_wr.chk});
	endproperty
	a_chk: assert property (p_chk) else $error("check bits");
	property p_nochk;
		dma_wr_valid && !data_rd.valid && !inst_rd.valid |=>
			$stable(data_err_count) && $stable(inst_err_count);
	endproperty
	a_nochk: assert property (p_nochk) else $error("dma write counted");
	property p_sat;
		data_err_count == CNT_MAX |=> data_err_count == CNT_MAX;
	endproperty
	a_sat: assert property (p_sat) else $error("count wrap");
	property p_dirq;
		$stable(data_thresh) |-> data_corr_irq == (data_thresh != 0 && data_err_count >= data_thresh);
	endproperty
	a_dirq: assert property (p_dirq) else $error("data irq");
	property p_iirq;
		$stable(inst_thresh) |-> inst_corr_irq == (inst_thresh != 0 && inst_err_count >= inst_thresh);
	endproperty
	a_iirq: assert property (p_iirq) else $error("inst irq");
	c_dcor: cover property (d_cor);
	c_icor: cover property (i_cor);
	c_irq: cover property ($rose(data_corr_irq));
endmodule : ecc_fix_properties

// file: tb/mem_model.sv
// Word store beside one memory port of the handler.
// Assumes bench requests; the data field of a request is an error mask.
`timescale 1ns/1ps
module mem_model (
	// Clock
	input wire logic clk,
	// Request and write
	input wire ecc_fix_pkg::mem_rd_s req,
	input wire ecc_fix_pkg::mem_wr_s wr,
	// Read result
	output ecc_fix_pkg::mem_rd_s rd
);
	import ecc_fix_pkg::*;
	logic [38:0] mem_q [16];
	mem_rd_s rd_q = '0;
	wire [3:0] a = req.addr[3:0];
	always @(posedge clk) begin
		rd_q <= req;
		rd_q.data <= mem_q[a][38:7] ^ req.data;
		rd_q.chk <= mem_q[a][6:0];
		if (req.valid && req.data != 0) begin
			mem_q[a] <= mem_q[a] ^ {req.data, 7'h00};
		end
		// Bus-side memories fix, count and interrupt on their own, not here
		if (wr.valid) begin
			mem_q[wr.addr[3:0]] <= {wr.data, wr.chk};
		end
		if (!req.valid) begin
			rd_q.data <= ~rd_q.data;
		end
	end
	assign rd = rd_q;
endmodule : mem_model

// file: tb/ecc_fix_bench.sv
// Self-checking bench for the correctable error handler.
// Assumes two word stores feed the read ports.
`timescale 1ns/1ps
module ecc_fix_bench;
	import ecc_fix_pkg::*;
	logic clk = 0, srst = 1, dma_wr_data_sel = 0, dma_wr_valid = 0;
	logic [CNT_W-1:0] data_thresh = 16'h0003, inst_thresh = 16'h0002;
	logic [ADDR_W-1:0] dma_wr_addr = '0;
	logic [DATA_W-1:0] dma_wr_data = '0, data_out, inst_out, words [8], exp_d [$], exp_i [$];
	mem_rd_s dreq = '0, ireq = '0, data_rd, inst_rd;
	mem_wr_s data_wr, inst_wr;
	logic data_out_valid, inst_out_valid, data_corr_irq, inst_corr_irq;
	logic data_out_uncorr, inst_out_uncorr, exp_du [$], exp_iu [$];
	logic [CNT_W-1:0] data_err_count, inst_err_count;
	int failures = 0, n_compared = 0, seed = 2;
	ecc_fix DUT (.clk, .srst, .data_thresh, .inst_thresh, .data_rd, .inst_rd, .dma_wr_data_sel,
		.dma_wr_valid, .dma_wr_addr, .dma_wr_data, .data_out_valid, .data_out,
		.data_out_uncorr, .inst_out_valid, .inst_out, .inst_out_uncorr, .data_wr, .inst_wr,
		.data_err_count, .inst_err_count, .data_corr_irq, .inst_corr_irq);
	mem_model dm (.clk, .req(dreq), .wr(data_wr), .rd(data_rd));
	mem_model im (.clk, .req(ireq), .wr(inst_wr), .rd(inst_rd));
	initial forever #25 clk = ~clk;
	task automatic final_report;
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	task automatic cmp(input string what, input logic [31:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	function automatic logic [31:0] flip();
		return 32'h1 << ($unsigned($random(seed)) % 32);
	endfunction : flip
	function automatic logic [31:0] dbl();
		logic [31:0] m;
		m = flip();
		return m | {m[30:0], m[31]};
	endfunction : dbl
	task automatic idle(input int n);
		@(negedge clk);
		dreq.valid = 0;
		ireq.valid = 0;
		repeat (n) @(negedge clk);
	endtask : idle
	task automatic rd(input logic sel, input access_e k, input logic sp, input int a,
		input logic [31:0] m);
		logic two;
		two = (m & (m - 32'h1)) != 32'h0;
		@(negedge clk);
		dreq = '{sel, k, sp, 16'(a), m, 7'h00};
		ireq = '{!sel, k, sp, 16'(a), m, 7'h00};
		if (sel && k != SRC_DMA_WRITE) begin
			exp_d.push_back(words[a] ^ (two ? m : 32'h0));
			exp_du.push_back(two);
		end
		if (!sel && k == SRC_DMA_READ) begin
			exp_i.push_back(words[a + 4] ^ (two ? m : 32'h0));
			exp_iu.push_back(two);
		end
	endtask : rd
	always @(negedge clk) begin
		if (data_out_valid === 1'b1) begin
			cmp("data_out", exp_d.pop_front(), data_out);
			cmp("data_out_uncorr", 32'(exp_du.pop_front()), 32'(data_out_uncorr));
		end
		if (inst_out_valid === 1'b1) begin
			cmp("inst_out", exp_i.pop_front(), inst_out);
			cmp("inst_out_uncorr", 32'(exp_iu.pop_front()), 32'(inst_out_uncorr));
		end
	end
	initial begin
		repeat (70000) @(posedge clk);
		failures++;
		final_report();
	end
	initial begin
		repeat (2) @(negedge clk);
		srst = 0;
		for (int i = 0; i < 8; i++) begin
			words[i] = $random(seed);
			@(negedge clk);
			dma_wr_valid = 1;
			dma_wr_data_sel = i < 4;
			dma_wr_addr = 16'(i % 4);
			dma_wr_data = words[i];
		end
		@(negedge clk);
		dma_wr_valid = 0;
		cmp("data_err_count", 32'h0, 32'(data_err_count));
		cmp("inst_err_count", 32'h0, 32'(inst_err_count));
		rd(1, SRC_CORE_LOAD, 0, 0, flip());
		rd(1, SRC_CORE_STORE, 0, 1, flip());
		rd(1, SRC_DMA_READ, 0, 2, flip());
		rd(1, SRC_CORE_LOAD, 1, 3, flip());
		rd(1, SRC_DMA_WRITE, 0, 0, flip());
		rd(0, SRC_DMA_READ, 0, 0, flip());
		rd(0, SRC_DMA_READ, 0, 1, flip());
		rd(0, SRC_CORE_LOAD, 0, 2, flip());
		for (int i = 0; i < 3; i++) rd(1, SRC_DMA_READ, 0, i, 0);
		for (int i = 0; i < 2; i++) rd(0, SRC_DMA_READ, 0, i, 0);
		rd(1, SRC_CORE_LOAD, 1, 3, 0);
		idle(3);
		// Error left at word 0 by the DMA write kind is counted by the DMA read
		cmp("data_err_count", 32'h4, 32'(data_err_count));
		cmp("inst_err_count", 32'h2, 32'(inst_err_count));
		cmp("data_corr_irq", 32'h1, 32'(data_corr_irq));
		cmp("inst_corr_irq", 32'h1, 32'(inst_corr_irq));
		// Drive the data count to its ceiling; addresses rotate past write-back
		for (int i = 0; i < 65540; i++) rd(1, SRC_CORE_LOAD, 0, i % 3, flip());
		idle(4);
		cmp("data_err_count", 32'hFFFF, 32'(data_err_count));
		rd(1, SRC_CORE_LOAD, 0, 1, dbl());
		rd(0, SRC_DMA_READ, 0, 3, dbl());
		idle(3);
		cmp("data_err_count", 32'hFFFF, 32'(data_err_count));
		cmp("inst_err_count", 32'h2, 32'(inst_err_count));
		cmp("pending", 32'h0, 32'(exp_d.size() + exp_i.size()));
		srst = 1;
		@(negedge clk);
		srst = 0;
		cmp("data_err_count", 32'h0, 32'(data_err_count));
		cmp("inst_err_count", 32'h0, 32'(inst_err_count));
		cmp("data_corr_irq", 32'h0, 32'(data_corr_irq));
		cmp("inst_corr_irq", 32'h0, 32'(inst_corr_irq));
		final_report();
	end
endmodule : ecc_fix_bench
bind ecc_fix ecc_fix_properties chk (.clk, .srst, .data_thresh, .inst_thresh, .data_rd,
	.inst_rd, .dma_wr_data_sel, .dma_wr_valid, .dma_wr_data, .data_wr, .inst_wr,
	.data_err_count, .inst_err_count, .data_corr_irq, .inst_corr_irq);
